// *** common/mfpd_pkg.sv ***
// package: constants and types for the multi-function pin config decoder
package mfpd_pkg;
    // data path of the register port
    localparam int MFPD_DATA_W = 8;
    // register word indexes on the plain port
    localparam int MFPD_ADDR_CFG = 0;
    localparam int MFPD_ADDR_STATUS = 1;
    localparam int MFPD_ADDR_GPO = 2;
    // reset values
    localparam logic [7:0] MFPD_CFG_RESET = 8'h00;
    localparam logic MFPD_GPO_RESET = 1'h0;
    localparam logic MFPD_PIN_IDLE = 1'h0;
    // configuration byte layout
    localparam int MFPD_ROLE_LSB = 0;
    localparam int MFPD_ROLE_MSB = 1;
    localparam int MFPD_OPT_LSB = 2;
    localparam int MFPD_OPT_MSB = 7;
    // option bits as seen in the output roles
    localparam int MFPD_OPT_POL = 5;
    localparam int MFPD_OPT_SPARE = 4;
    localparam int MFPD_OPT_RAIL = 3;
    localparam int MFPD_OPT_PU = 2;
    localparam int MFPD_OPT_DRV = 1;
    localparam int MFPD_OPT_PD = 0;
    // option pairs as seen in the analog role (low bit of each pair)
    localparam int MFPD_APULL_LSB = 4;
    localparam int MFPD_POLY_LSB = 2;
    localparam int MFPD_MEAS_LSB = 0;
    // general output level bit in its register
    localparam int MFPD_GPO_BIT = 0;
    // status register bits
    localparam int MFPD_ST_OUT_ROLE = 0;
    localparam int MFPD_ST_ANALOG = 1;
    localparam int MFPD_ST_PU_CLASH = 2;
    localparam int MFPD_ST_PIN_OE = 3;
    localparam int MFPD_ST_PIN_OUT = 4;
    localparam int MFPD_ST_RX = 5;

    typedef enum logic [1:0] {
        MFPD_ROLE_COMM = 2'h0,
        MFPD_ROLE_GPO = 2'h1,
        MFPD_ROLE_UNUSED = 2'h2,
        MFPD_ROLE_ANALOG = 2'h3
    } mfpd_role_t;

    typedef enum logic [1:0] {
        MFPD_APULL_18K = 2'h0,
        MFPD_APULL_180K = 2'h1,
        MFPD_APULL_NONE = 2'h2,
        MFPD_APULL_RSVD = 2'h3
    } mfpd_apull_t;

    typedef enum logic [1:0] {
        MFPD_POLY_18K = 2'h0,
        MFPD_POLY_180K = 2'h1,
        MFPD_POLY_CUSTOM = 2'h2,
        MFPD_POLY_RAW = 2'h3
    } mfpd_poly_t;

    typedef enum logic [1:0] {
        MFPD_MEAS_GENERAL = 2'h0,
        MFPD_MEAS_CELL = 2'h1,
        MFPD_MEAS_REPORT = 2'h2,
        MFPD_MEAS_FET = 2'h3
    } mfpd_meas_t;
endpackage : mfpd_pkg

// *** verilog/mfpd_pin_sync.sv ***
// module: three-stage synchroniser for the pad input level
`timescale 1ns/1ps
module mfpd_pin_sync
    import mfpd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    // shift chain; s1 feeds only s2 to keep metastability contained
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= MFPD_PIN_IDLE;
            s2 <= MFPD_PIN_IDLE;
            s3 <= MFPD_PIN_IDLE;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // accept a new level only once the last two stages agree
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            level <= MFPD_PIN_IDLE;
        else if (s2 == s3)
            level <= s3;
    end
endmodule : mfpd_pin_sync

// *** verilog/mfpd_pin_config.sv ***
// module: register and decoder for one multi-function pin configuration byte
`timescale 1ns/1ps
module mfpd_pin_config
    import mfpd_pkg::*;
#(
    parameter int ADDR_W = 4
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [MFPD_DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [MFPD_DATA_W-1:0] rdata,
    input wire logic comm_assert,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic rail_sel_second,
    output logic weak_pullup_en,
    output logic weak_pulldown_en,
    output logic comm_rx_level,
    output logic output_role,
    output logic analog_active,
    output logic pull_18k_en,
    output logic pull_180k_en,
    output logic [1:0] poly_sel,
    output logic raw_counts,
    output logic [1:0] meas_type,
    output logic cell_prot_en,
    output logic fet_prot_en,
    output logic report_only
);
    // the index constants must fit the address port
    generate
        if (ADDR_W < 2 || ADDR_W > 16)
        begin : g_bad_addr_w
            $error("mfpd_pin_config: ADDR_W must lie in 2..16");
        end
    endgenerate

    logic [MFPD_DATA_W-1:0] cfg;
    logic gpo_level;
    logic rx_level;
    mfpd_role_t role;
    logic [5:0] opt;
    logic cfg_wr;
    logic out_role_now;
    logic cmd_high;
    logic next_pin_out;
    logic next_pin_oe;
    logic next_rail;
    logic next_pu;
    logic next_pd;
    logic next_pull_18k;
    logic next_pull_180k;
    logic [MFPD_DATA_W-1:0] next_rdata;
    logic [MFPD_DATA_W-1:0] status;

    // pick a two-bit analog setting out of the option field
    function automatic logic [1:0] opt_pair(input logic [5:0] o, input int lsb);
        opt_pair = o[lsb +: 2];
    endfunction : opt_pair

    // both comm and general output drive the pad
    function automatic logic is_out_role(input mfpd_role_t r);
        is_out_role = (r == MFPD_ROLE_COMM) || (r == MFPD_ROLE_GPO);
    endfunction : is_out_role

    // address match against a register index
    function automatic logic hit(input logic [ADDR_W-1:0] a, input int idx);
        hit = (a == ADDR_W'(idx));
    endfunction : hit

    // field split of the stored byte
    assign role = mfpd_role_t'(cfg[MFPD_ROLE_MSB:MFPD_ROLE_LSB]);
    assign opt = cfg[MFPD_OPT_MSB:MFPD_OPT_LSB];
    assign cfg_wr = wr_en && hit(addr, MFPD_ADDR_CFG);
    assign out_role_now = is_out_role(role);

    // pad level synchroniser for the serial data-in path
    mfpd_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(pin_in),
        .level(rx_level)
    );

    // configuration byte; the whole byte is writable
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg <= MFPD_CFG_RESET;
        else if (cfg_wr)
            cfg <= wdata;
    end

    // level commanded in the general output role
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            gpo_level <= MFPD_GPO_RESET;
        else if (wr_en && hit(addr, MFPD_ADDR_GPO))
            gpo_level <= wdata[MFPD_GPO_BIT];
    end

    // commanded pad level per role
    always_comb
    begin
        case (role)
            MFPD_ROLE_COMM: cmd_high = comm_assert ^ opt[MFPD_OPT_POL];
            MFPD_ROLE_GPO: cmd_high = gpo_level;
            default: cmd_high = 1'h0;
        endcase
    end

    // driver decode; rail select forbids floating, so it forces a real drive
    always_comb
    begin
        next_pin_out = 1'h0;
        next_pin_oe = 1'h0;
        if (out_role_now)
        begin
            if (!cmd_high)
                next_pin_oe = 1'h1;
            else if (opt[MFPD_OPT_DRV] || opt[MFPD_OPT_RAIL])
            begin
                next_pin_out = 1'h1;
                next_pin_oe = 1'h1;
            end
        end
    end

    // rail and weak pulls; bit 4 is not looked at in these roles
    always_comb
    begin
        next_rail = out_role_now && opt[MFPD_OPT_RAIL];
        next_pu = out_role_now && opt[MFPD_OPT_PU];
        next_pd = out_role_now && opt[MFPD_OPT_PD];
    end

    // analog pull-up choice; the reserved code leaves the pin unloaded
    always_comb
    begin
        next_pull_18k = 1'h0;
        next_pull_180k = 1'h0;
        if (role == MFPD_ROLE_ANALOG)
        begin
            case (mfpd_apull_t'(opt_pair(opt, MFPD_APULL_LSB)))
                MFPD_APULL_18K: next_pull_18k = 1'h1;
                MFPD_APULL_180K: next_pull_180k = 1'h1;
                MFPD_APULL_RSVD: next_pull_18k = 1'h0;
                default: next_pull_18k = 1'h0;
            endcase
        end
    end

    // pad drivers, registered so no decode glitch reaches the pin
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out <= MFPD_PIN_IDLE;
            pin_oe <= 1'h0;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

    // rail select and weak pulls
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rail_sel_second <= 1'h0;
            weak_pullup_en <= 1'h0;
            weak_pulldown_en <= 1'h0;
        end
        else
        begin
            rail_sel_second <= next_rail;
            weak_pullup_en <= next_pu;
            weak_pulldown_en <= next_pd;
        end
    end

    // role flags and received data level
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            output_role <= 1'h0;
            analog_active <= 1'h0;
            comm_rx_level <= MFPD_PIN_IDLE;
        end
        else
        begin
            output_role <= out_role_now;
            analog_active <= (role == MFPD_ROLE_ANALOG);
            comm_rx_level <= (role == MFPD_ROLE_COMM) && rx_level;
        end
    end

    // measurement settings; all zero outside the analog role
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pull_18k_en <= 1'h0;
            pull_180k_en <= 1'h0;
            poly_sel <= MFPD_POLY_18K;
            raw_counts <= 1'h0;
            meas_type <= MFPD_MEAS_GENERAL;
            cell_prot_en <= 1'h0;
            fet_prot_en <= 1'h0;
            report_only <= 1'h0;
        end
        else if (role == MFPD_ROLE_ANALOG)
        begin
            pull_18k_en <= next_pull_18k;
            pull_180k_en <= next_pull_180k;
            poly_sel <= opt_pair(opt, MFPD_POLY_LSB);
            raw_counts <= (opt_pair(opt, MFPD_POLY_LSB) == MFPD_POLY_RAW);
            meas_type <= opt_pair(opt, MFPD_MEAS_LSB);
            cell_prot_en <= (opt_pair(opt, MFPD_MEAS_LSB) == MFPD_MEAS_CELL);
            fet_prot_en <= (opt_pair(opt, MFPD_MEAS_LSB) == MFPD_MEAS_FET);
            report_only <= (opt_pair(opt, MFPD_MEAS_LSB) == MFPD_MEAS_REPORT);
        end
        else
        begin
            pull_18k_en <= 1'h0;
            pull_180k_en <= 1'h0;
            poly_sel <= MFPD_POLY_18K;
            raw_counts <= 1'h0;
            meas_type <= MFPD_MEAS_GENERAL;
            cell_prot_en <= 1'h0;
            fet_prot_en <= 1'h0;
            report_only <= 1'h0;
        end
    end

    // status view; the clash bit flags a setting software should avoid
    always_comb
    begin
        status = '0;
        status[MFPD_ST_OUT_ROLE] = output_role;
        status[MFPD_ST_ANALOG] = analog_active;
        status[MFPD_ST_PU_CLASH] = weak_pullup_en && rail_sel_second;
        status[MFPD_ST_PIN_OE] = pin_oe;
        status[MFPD_ST_PIN_OUT] = pin_out;
        status[MFPD_ST_RX] = comm_rx_level;
    end

    // read mux; unmapped indexes read as zero
    always_comb
    begin
        next_rdata = '0;
        if (hit(addr, MFPD_ADDR_CFG))
            next_rdata = cfg;
        else if (hit(addr, MFPD_ADDR_STATUS))
            next_rdata = status;
        else if (hit(addr, MFPD_ADDR_GPO))
            next_rdata[MFPD_GPO_BIT] = gpo_level;
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= '0;
        else if (rd_en)
            rdata <= next_rdata;
        else
            rdata <= '0;
    end

    // checks on the decode, one clock domain throughout
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // a config write followed by the decode cycle
    sequence s_cfg_write;
        wr_en && hit(addr, MFPD_ADDR_CFG);
    endsequence

    sequence s_analog_set;
        s_cfg_write ##1 (role == MFPD_ROLE_ANALOG);
    endsequence

    cfg_write_a: assert property (
        s_cfg_write |=> cfg == $past(wdata) ##1 analog_active == ($past(role) == MFPD_ROLE_ANALOG))
        else $error("config write did not reach the role decode");

    reset_default_a: assert property (
        $rose(rst_n) |-> cfg == MFPD_CFG_RESET && !pin_oe && !analog_active)
        else $error("config byte not cleared by reset");

    comm_polarity_a: assert property (
        (role == MFPD_ROLE_COMM && opt[MFPD_OPT_DRV] && !opt[MFPD_OPT_RAIL])
        |=> pin_oe && pin_out == ($past(comm_assert) ^ $past(opt[MFPD_OPT_POL])))
        else $error("comm polarity not applied");

    gpo_polarity_a: assert property (
        (role == MFPD_ROLE_GPO && opt[MFPD_OPT_DRV]) |=> pin_out == $past(gpo_level))
        else $error("general output level altered by polarity bit");

    rail_select_a: assert property (
        out_role_now |=> rail_sel_second == $past(opt[MFPD_OPT_RAIL]))
        else $error("rail select does not follow option bit 3");

    pullup_ctl_a: assert property (
        out_role_now |=> weak_pullup_en == $past(opt[MFPD_OPT_PU]))
        else $error("weak pull-up does not follow option bit 2");

    float_high_a: assert property (
        (out_role_now && cmd_high && !opt[MFPD_OPT_DRV] && !opt[MFPD_OPT_RAIL])
        |=> !pin_oe)
        else $error("commanded high not floated");

    rail_drive_a: assert property (
        (out_role_now && cmd_high && opt[MFPD_OPT_RAIL]) |=> pin_oe && pin_out)
        else $error("rail select did not force an active high");

    pulldown_ctl_a: assert property (
        out_role_now |=> weak_pulldown_en == $past(opt[MFPD_OPT_PD]))
        else $error("weak pull-down does not follow option bit 0");

    analog_reuse_a: assert property (
        s_analog_set |=> !pin_oe && !weak_pullup_en && !weak_pulldown_en && !rail_sel_second)
        else $error("output controls active in analog role");

    analog_pull_a: assert property (
        (role == MFPD_ROLE_ANALOG) |=> pull_18k_en == ($past(opt[5:4]) == MFPD_APULL_18K)
        && pull_180k_en == ($past(opt[5:4]) == MFPD_APULL_180K))
        else $error("analog pull-up selection wrong");

    poly_sel_a: assert property (
        (role == MFPD_ROLE_ANALOG) |=> poly_sel == $past(opt[3:2])
        && raw_counts == ($past(opt[3:2]) == MFPD_POLY_RAW))
        else $error("conversion model selection wrong");

    meas_type_a: assert property (
        (role == MFPD_ROLE_ANALOG && opt[1:0] == MFPD_MEAS_FET)
        |=> fet_prot_en && !cell_prot_en && !report_only && meas_type == MFPD_MEAS_FET)
        else $error("measurement type decode wrong");

    reserved_pull_a: assert property (
        (role == MFPD_ROLE_ANALOG && opt[5:4] == MFPD_APULL_RSVD)
        |=> !pull_18k_en && !pull_180k_en)
        else $error("reserved pull-up code applied a resistor");

    read_timing_a: assert property (
        (rd_en && hit(addr, MFPD_ADDR_CFG)) |=> rdata == $past(cfg) ##1 ($past(rd_en) || rdata == '0))
        else $error("read data not aligned to the strobe");
endmodule : mfpd_pin_config

// *** tb/test_mfpd_pin_config.sv ***
// self-checking testbench for the pin configuration decoder
`timescale 1ns/1ps
module test_mfpd_pin_config
    import mfpd_pkg::*;
;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'h0;
    logic rd_en = 1'h0;
    logic comm_assert = 1'h0;
    logic pin_in = 1'h0;
    logic [7:0] rdata;
    logic pin_out, pin_oe, rail_sel_second, weak_pullup_en, weak_pulldown_en;
    logic comm_rx_level, output_role, analog_active, pull_18k_en, pull_180k_en;
    logic [1:0] poly_sel;
    logic raw_counts;
    logic [1:0] meas_type;
    logic cell_prot_en, fet_prot_en, report_only;
    logic [16:0] obs;
    logic [31:0] seed = 32'h00000013;
    int fails = 0;
    int compares = 0;
    // field groups inside the packed decode vector
    localparam logic [16:0] M_DRV = 17'h1F000;
    localparam logic [16:0] M_ROLE = 17'h00C00;
    localparam logic [16:0] M_ANA = 17'h003FF;

    mfpd_pin_config #(.ADDR_W(4)) u_mfpd_pin_config (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .comm_assert(comm_assert), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .rail_sel_second(rail_sel_second),
        .weak_pullup_en(weak_pullup_en), .weak_pulldown_en(weak_pulldown_en),
        .comm_rx_level(comm_rx_level), .output_role(output_role),
        .analog_active(analog_active), .pull_18k_en(pull_18k_en),
        .pull_180k_en(pull_180k_en), .poly_sel(poly_sel), .raw_counts(raw_counts),
        .meas_type(meas_type), .cell_prot_en(cell_prot_en), .fet_prot_en(fet_prot_en),
        .report_only(report_only)
    );

    // free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // all decoded controls in one vector so one compare covers a group
    assign obs = {pin_out, pin_oe, rail_sel_second, weak_pullup_en, weak_pulldown_en,
        output_role, analog_active, pull_18k_en, pull_180k_en, poly_sel, raw_counts,
        meas_type, cell_prot_en, fet_prot_en, report_only};

    // xorshift keeps the run repeatable without a simulator seed
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    // expected decode of a config byte, comm level and general output level
    function automatic logic [16:0] exp_dec(input logic [7:0] c, input logic ca,
        input logic g);
        logic [5:0] o;
        logic outr, ana, cmd, oe, po;
        o = c[7:2];
        outr = (c[1:0] <= 2'h1);
        ana = (c[1:0] == 2'h3);
        cmd = (c[1:0] == 2'h0) ? (ca ^ o[5]) : g;
        oe = outr & (!cmd | o[1] | o[3]);
        po = outr & cmd & (o[1] | o[3]);
        return {po, oe, outr & o[3], outr & o[2], outr & o[0], outr, ana,
            ana & (o[5:4] == 2'h0), ana & (o[5:4] == 2'h1), ana ? o[3:2] : 2'h0,
            ana & (o[3:2] == 2'h3), ana ? o[1:0] : 2'h0, ana & (o[1:0] == 2'h1),
            ana & (o[1:0] == 2'h3), ana & (o[1:0] == 2'h2)};
    endfunction : exp_dec

    task check(input logic [16:0] seen, input logic [16:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // one-cycle write strobe, taken at the second edge
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge ref_clk);
        wr_en <= 1'h0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        #1 d = rdata;
    endtask : rd

    task wrap_up();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // cut a hang short; the full run needs about 4200 cycles
    initial
    begin
        repeat (12000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end

    initial
    begin
        logic [7:0] cfg, d;
        logic [31:0] r;
        logic [16:0] e;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        #1 check(obs, exp_dec(8'h00, 1'h0, 1'h0), "reset decode");
        rd(4'(MFPD_ADDR_CFG), d);
        check({9'h0, d}, 17'h00000, "reset cfg");
        // every config byte once, then random ones, with random drive levels
        for (int i = 0; i < 320; i++)
        begin
            r = next_rand();
            cfg = (i < 256) ? 8'(i) : r[15:8];
            wr(4'(MFPD_ADDR_GPO), {7'h0, r[0]});
            wr(4'(MFPD_ADDR_CFG), cfg);
            comm_assert <= r[1];
            repeat (3) @(posedge ref_clk);
            e = exp_dec(cfg, r[1], r[0]);
            #1 check(obs & M_ROLE, e & M_ROLE, "role");
            check(obs & M_DRV, e & M_DRV, "drive");
            check(obs & M_ANA, e & M_ANA, "analog");
            rd(4'(MFPD_ADDR_CFG), d);
            check({9'h0, d}, {9'h0, cfg}, "cfg readback");
            rd(4'(MFPD_ADDR_STATUS), d);
            check({9'h0, d}, {12'h0, e[16], e[15], e[11] & cfg[4] & cfg[5], e[10], e[11]},
                "status");
            rd(4'(MFPD_ADDR_GPO), d);
            check({9'h0, d}, {16'h0, r[0]}, "gpo readback");
        end
        @(posedge ref_clk);
        #1 check({9'h0, rdata}, 17'h00000, "rdata after read");
        // writes to status and unmapped places are ignored
        wr(4'(MFPD_ADDR_STATUS), 8'hFF);
        wr(4'hF, 8'hAA);
        rd(4'hF, d);
        check({9'h0, d}, 17'h00000, "unmapped read");
        rd(4'(MFPD_ADDR_CFG), d);
        check({9'h0, d}, {9'h0, cfg}, "cfg kept");
        // pad level reaches the comm receiver only through the synchroniser
        wr(4'(MFPD_ADDR_CFG), 8'h00);
        pin_in <= 1'h1;
        repeat (2) @(posedge ref_clk);
        #1 check({16'h0, comm_rx_level}, 17'h00000, "rx too early");
        repeat (4) @(posedge ref_clk);
        #1 check({16'h0, comm_rx_level}, 17'h00001, "rx level");
        // a one-cycle dip must not pass the agree filter
        pin_in <= 1'h0;
        @(posedge ref_clk);
        pin_in <= 1'h1;
        repeat (4) @(posedge ref_clk);
        #1 check({16'h0, comm_rx_level}, 17'h00001, "rx glitch filtered");
        rd(4'(MFPD_ADDR_STATUS), d);
        check({16'h0, d[MFPD_ST_RX]}, 17'h00001, "status rx");
        wr(4'(MFPD_ADDR_CFG), 8'h01);
        repeat (3) @(posedge ref_clk);
        #1 check({16'h0, comm_rx_level}, 17'h00000, "rx outside comm");
        // reset in mid-run clears everything back to the comm role
        wr(4'(MFPD_ADDR_CFG), 8'h07);
        @(posedge ref_clk);
        rst_n <= 1'h0;
        #1 check(obs, 17'h00000, "outputs in reset");
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        #1 check(obs, exp_dec(8'h00, comm_assert, 1'h0), "decode after reset");
        rd(4'(MFPD_ADDR_CFG), d);
        check({9'h0, d}, 17'h00000, "cfg after reset");
        wrap_up();
    end
endmodule : test_mfpd_pin_config
